// [bsfs_pkg.sv]
// constants, types and register layout of the start-up and fault sequencer
package bsfs_pkg;
    // clock rate
    localparam int unsigned CLK_KHZ = 40000;
    localparam int unsigned CLK_MHZ = 40;
    // soft-start level in microvolts, rising at 0.2 mV per microsecond
    localparam int unsigned SS_RATE_UV_PER_US = 200;
    localparam logic [21:0] SS_STEP_UV        = 22'(SS_RATE_UV_PER_US / CLK_MHZ);
    localparam logic [21:0] SS_CLAMP_UV       = 22'(1500000);
    localparam logic [21:0] SS_FORCED_UV      = 22'(3000000);
    localparam logic [21:0] SS_START_UV       = 22'(150000);
    // output ramp time and hiccup blanking time, in microseconds
    localparam int unsigned RAMP_TIME_US   = 3000;
    localparam int unsigned HICCUP_TIME_US = 20480;
    localparam int unsigned RAMP_CYC_DEF   = RAMP_TIME_US * CLK_MHZ;
    localparam int unsigned HICCUP_CYC_DEF = HICCUP_TIME_US * CLK_MHZ;
    // over-voltage filter delay and over-current sample window, in ns
    localparam int unsigned OVP_DELAY_NS  = 2000;
    localparam logic [6:0]  OVP_DELAY_CYC = 7'(OVP_DELAY_NS * CLK_MHZ / 1000);
    localparam int unsigned OCP_SAMPLE_NS = 40;
    localparam logic [8:0]  OCP_SAMPLE_CYC =
        9'((OCP_SAMPLE_NS * CLK_MHZ / 1000) > 0 ? (OCP_SAMPLE_NS * CLK_MHZ / 1000) : 1);
    // switching frequency table: 300 kHz plus 100 kHz per code step
    localparam int unsigned FS_BASE_KHZ = 300;
    localparam int unsigned FS_STEP_KHZ = 100;
    localparam logic [3:0]  FS_CODE_MAX = 4'hC;
    // pre-bias sync switch schedule
    localparam logic [3:0]  EIGHTHS         = 4'h8;
    localparam logic [3:0]  PULSES_PER_STEP = 4'hF;  // last pulse index of a step
    localparam logic [3:0]  STEP_FIRST      = 4'h1;
    // current limit select strap codes
    localparam logic [1:0]  LIM_OPEN = 2'h0;
    localparam logic [1:0]  LIM_HIGH = 2'h1;
    localparam logic [1:0]  LIM_LOW  = 2'h2;
    // register byte offsets
    localparam logic [3:0]  REG_CTRL   = 4'h0;
    localparam logic [3:0]  REG_STATUS = 4'h4;
    localparam logic [3:0]  REG_SSLVL  = 4'h8;
    localparam logic [3:0]  REG_FAULTS = 4'hC;
    localparam logic        CTRL_RESET = 1'b0;

    typedef enum logic [1:0] {ST_LOCKOUT, ST_ACTIVE, ST_HICCUP, ST_THERMAL} bsfs_state_t;

    // synchronous comparator flags from the analog front end
    typedef struct packed {
        logic       bias_ok;          // bias supply node above its lockout threshold
        logic       en_above_on;      // enable above 1.2 V rising threshold
        logic       en_above_off;     // enable above 1.0 V falling threshold
        logic       temp_hot;         // die above the trip point
        logic       temp_below_hyst;  // die below trip point minus hysteresis
        logic       sns_above_low;    // sense above 85 % of reference
        logic       sns_above_high;   // sense above 120 % of reference
        logic [2:0] ocp_over;         // valley current above limit, one per setting
    } bsfs_cmp_t;

    // gate driver enables
    typedef struct packed {
        logic hs_on;
        logic ls_on;
    } bsfs_gate_t;

    // status register layout
    typedef struct packed {
        logic [18:0] zero;
        logic [3:0]  ls_step;
        logic [1:0]  pad;
        logic        hs_seen;
        logic        por;
        logic        ramp;
        logic        ovp;
        logic        pg;
        logic [1:0]  state;
    } bsfs_status_t;
endpackage

// [bsfs_sequencer.sv]
// start-up, soft-start, pre-bias and fault sequencer of a buck converter controller
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - gates off while bias or enable low
// - resume only when bias and enable valid
// - valid inputs give ready, launching soft-start
// - turn on above enable rising threshold
// - enable below falling threshold: both off
// - sync switch off until first high-side pulse
// - sync duty eighths, 16 pulses per step
// - soft-start 0.2 mV/us to 1.5 V, then 3 V
// - ramp starts past 0.15 V, lasts 3 ms
// - current and voltage protection during soft-start
// - frequency 300 to 1500 kHz by resistor code
// - three current limits from select strap
// - sample current before valley, flag over-limit
// - over-current: power-good low, 20.48 ms off
// - retry hiccup while overload persists
// - thermal trip: both off, soft-start reset
// - thermal restart after 20 C hysteresis
// - power-good only inside 85-120 % window
// - 2 us over-voltage latches high side off
// - sync on while over; latch clears on cycling
module bsfs_sequencer #(
    parameter int unsigned RAMP_CYCLES   = bsfs_pkg::RAMP_CYC_DEF,
    parameter int unsigned HICCUP_CYCLES = bsfs_pkg::HICCUP_CYC_DEF
) (
    // clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  arst_n_in,
    // comparator flags, straps and modulator
    input  wire bsfs_pkg::bsfs_cmp_t   cmp_in,
    input  wire logic [1:0]            current_limit_select_in,
    input  wire logic [3:0]            frequency_set_resistor_in,
    input  wire logic                  pwm_in,
    // gate drives and flags
    output var   bsfs_pkg::bsfs_gate_t gate_out,
    output logic                       pg_out,
    output logic                       por_ready_out,
    output logic                       ramp_active_out,
    output logic [21:0]                soft_start_level_out,
    // avalon-mm slave
    input  wire logic [3:0]            avs_address_in,
    input  wire logic                  avs_read_in,
    input  wire logic                  avs_write_in,
    input  wire logic [31:0]           avs_writedata_in,
    input  wire logic [3:0]            avs_byteenable_in,
    output logic [31:0]                avs_readdata_out,
    output logic                       avs_waitrequest_out
);

    typedef struct packed {
        bsfs_pkg::bsfs_state_t st;
        logic [21:0] ss_uv;
        logic [16:0] ramp_cnt;
        logic        ramp_act;
        logic [19:0] blank_cnt;
        logic [6:0]  ovp_cnt;
        logic        ovp_latch;
        logic [8:0]  since_rise;
        logic [8:0]  since_fall;
        logic [3:0]  step;
        logic [3:0]  pulse_cnt;
        logic        hs_seen;
        logic        hs;
        logic        ls;
        logic        pg;
        logic        sw_off;
        logic [7:0]  faults;
        logic        ack;
        logic [31:0] rdata;
    } bsfs_regs_t;

    bsfs_regs_t s;
    bsfs_regs_t next_s;
    logic       lock;
    logic [8:0] period;
    logic [8:0] eighth;
    logic [1:0] lim_sel;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // switching period in clock cycles for a resistor code
    function automatic logic [8:0] period_cyc(input logic [3:0] code);
        logic [3:0] c;
        c = (code > bsfs_pkg::FS_CODE_MAX) ? bsfs_pkg::FS_CODE_MAX : code;
        return 9'(bsfs_pkg::CLK_KHZ / (bsfs_pkg::FS_BASE_KHZ + bsfs_pkg::FS_STEP_KHZ * c));
    endfunction

    // saturating 9-bit phase counter step
    function automatic logic [8:0] sat_inc(input logic [8:0] v);
        return (v == 9'h1FF) ? v : 9'(v + 9'h1);
    endfunction

    // lockout when bias or enable below falling threshold or software off
    assign lock    = !cmp_in.bias_ok || !cmp_in.en_above_off || s.sw_off;
    assign period  = period_cyc(frequency_set_resistor_in);
    assign eighth  = 9'(period / 9'(bsfs_pkg::EIGHTHS));
    // unused strap code behaves as open
    assign lim_sel = (current_limit_select_in == 2'h3) ? bsfs_pkg::LIM_OPEN
                                                       : current_limit_select_in;

    ////////////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        logic        sw_en;
        logic        oc_evt;
        logic        hs_n;
        logic [21:0] ss_inc;
        sw_en  = 1'b0;
        oc_evt = 1'b0;
        hs_n   = 1'b0;
        ss_inc = 22'(s.ss_uv + bsfs_pkg::SS_STEP_UV);
        next_s = s;

        // current sampled for one window an eighth period before the valley
        oc_evt = (s.st == bsfs_pkg::ST_ACTIVE) && s.ls
                 && (s.since_rise >= 9'(period - eighth))
                 && (s.since_rise < 9'(period - eighth + bsfs_pkg::OCP_SAMPLE_CYC))
                 && cmp_in.ocp_over[lim_sel];

        // sequencer state
        if (lock) begin
            next_s.st = bsfs_pkg::ST_LOCKOUT;
        end else begin
            case (s.st)
                bsfs_pkg::ST_LOCKOUT: begin
                    if (cmp_in.bias_ok && cmp_in.en_above_on) begin
                        next_s.st = bsfs_pkg::ST_ACTIVE;
                    end
                end
                bsfs_pkg::ST_ACTIVE: begin
                    if (cmp_in.temp_hot) begin
                        next_s.st = bsfs_pkg::ST_THERMAL;
                    end else if (oc_evt) begin
                        next_s.st        = bsfs_pkg::ST_HICCUP;
                        next_s.blank_cnt = 20'h0;
                        next_s.faults    = (s.faults == 8'hFF) ? s.faults : 8'(s.faults + 8'h1);
                    end
                end
                bsfs_pkg::ST_HICCUP: begin
                    if (cmp_in.temp_hot) begin
                        next_s.st = bsfs_pkg::ST_THERMAL;
                    end else if (32'(s.blank_cnt) >= HICCUP_CYCLES - 1) begin
                        next_s.st = bsfs_pkg::ST_ACTIVE;
                    end else begin
                        next_s.blank_cnt = 20'(s.blank_cnt + 20'h1);
                    end
                end
                bsfs_pkg::ST_THERMAL: begin
                    if (cmp_in.temp_below_hyst) begin
                        next_s.st = bsfs_pkg::ST_ACTIVE;
                    end
                end
                default: next_s.st = bsfs_pkg::ST_LOCKOUT;
            endcase
        end

        // soft-start level and output ramp timing
        if (next_s.st != bsfs_pkg::ST_ACTIVE || s.st != bsfs_pkg::ST_ACTIVE) begin
            next_s.ss_uv    = 22'h0;
            next_s.ramp_cnt = 17'h0;
            next_s.ramp_act = 1'b0;
        end else begin
            if (s.ss_uv < bsfs_pkg::SS_CLAMP_UV) begin
                next_s.ss_uv = (ss_inc >= bsfs_pkg::SS_CLAMP_UV) ? bsfs_pkg::SS_FORCED_UV : ss_inc;
            end
            if (s.ss_uv > bsfs_pkg::SS_START_UV && 32'(s.ramp_cnt) < RAMP_CYCLES) begin
                next_s.ramp_cnt = 17'(s.ramp_cnt + 17'h1);
            end
            next_s.ramp_act = (s.ss_uv > bsfs_pkg::SS_START_UV) && (32'(next_s.ramp_cnt) < RAMP_CYCLES);
        end
        sw_en = (next_s.st == bsfs_pkg::ST_ACTIVE) && (s.ss_uv > bsfs_pkg::SS_START_UV);

        // over-voltage filter and latch, cleared only by lockout
        if (lock) begin
            next_s.ovp_cnt   = 7'h0;
            next_s.ovp_latch = 1'b0;
        end else if (cmp_in.sns_above_high) begin
            if (s.ovp_cnt < bsfs_pkg::OVP_DELAY_CYC - 7'h1) begin
                next_s.ovp_cnt = 7'(s.ovp_cnt + 7'h1);
            end else begin
                next_s.ovp_latch = 1'b1;
            end
        end else begin
            next_s.ovp_cnt = 7'h0;
        end

        // high-side gate follows modulator while switching is allowed
        hs_n      = sw_en && pwm_in && !next_s.ovp_latch;
        next_s.hs = hs_n;
        next_s.since_rise = (hs_n && !s.hs) ? 9'h0 : sat_inc(s.since_rise);
        next_s.since_fall = (!hs_n && s.hs) ? 9'h0 : sat_inc(s.since_fall);

        // pre-bias schedule: count pulses, widen sync duty by eighths
        if (!sw_en) begin
            next_s.hs_seen   = 1'b0;
            next_s.step      = bsfs_pkg::STEP_FIRST;
            next_s.pulse_cnt = 4'h0;
        end else if (hs_n && !s.hs) begin
            next_s.hs_seen = 1'b1;
            if (s.hs_seen) begin
                next_s.pulse_cnt = 4'(s.pulse_cnt + 4'h1);
                if (s.pulse_cnt == bsfs_pkg::PULSES_PER_STEP && s.step < bsfs_pkg::EIGHTHS) begin
                    next_s.step = 4'(s.step + 4'h1);
                end
            end
        end

        // low-side gate
        if (next_s.ovp_latch) begin
            next_s.ls = cmp_in.sns_above_high;
        end else if (!sw_en || !next_s.hs_seen || hs_n) begin
            next_s.ls = 1'b0;
        end else if (next_s.step >= bsfs_pkg::EIGHTHS) begin
            next_s.ls = 1'b1;
        end else begin
            next_s.ls = (next_s.since_fall < 9'(eighth * next_s.step));
        end

        // power-good window, forced low outside normal operation
        next_s.pg = (next_s.st == bsfs_pkg::ST_ACTIVE) && !next_s.ovp_latch
                    && cmp_in.sns_above_low && !cmp_in.sns_above_high;

        // avalon slave: one wait cycle, then answer
        next_s.ack = (avs_read_in || avs_write_in) && !s.ack;
        if (avs_read_in && !s.ack) begin
            case (avs_address_in)
                bsfs_pkg::REG_CTRL:   next_s.rdata = {31'h0, s.sw_off};
                bsfs_pkg::REG_STATUS: next_s.rdata = bsfs_pkg::bsfs_status_t'{
                    zero: 19'h0, ls_step: s.step, pad: 2'h0, hs_seen: s.hs_seen,
                    por: (s.st != bsfs_pkg::ST_LOCKOUT), ramp: s.ramp_act,
                    ovp: s.ovp_latch, pg: s.pg, state: s.st};
                bsfs_pkg::REG_SSLVL:  next_s.rdata = {10'h0, s.ss_uv};
                bsfs_pkg::REG_FAULTS: next_s.rdata = {24'h0, s.faults};
                default:              next_s.rdata = 32'h0;
            endcase
        end
        if (avs_write_in && s.ack && avs_address_in == bsfs_pkg::REG_CTRL && avs_byteenable_in[0]) begin
            next_s.sw_off = avs_writedata_in[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s        <= '0;
            s.st     <= bsfs_pkg::ST_LOCKOUT;
            s.step   <= bsfs_pkg::STEP_FIRST;
            s.sw_off <= bsfs_pkg::CTRL_RESET;
        end else begin
            s <= next_s;
        end
    end

    // outputs
    assign gate_out.hs_on        = s.hs;
    assign gate_out.ls_on        = s.ls;
    assign pg_out                = s.pg;
    assign por_ready_out         = (s.st != bsfs_pkg::ST_LOCKOUT);
    assign ramp_active_out       = s.ramp_act;
    assign soft_start_level_out  = s.ss_uv;
    assign avs_readdata_out      = s.rdata;
    assign avs_waitrequest_out   = (avs_read_in || avs_write_in) && !s.ack;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    property p_lock_off;
        !cmp_in.bias_ok |=> !gate_out.hs_on && !gate_out.ls_on && !pg_out;
    endproperty
    a_lock_off: assert property (p_lock_off) else $error("gates not off in lockout");

    property p_en_fall;
        !cmp_in.en_above_off |=> s.st == bsfs_pkg::ST_LOCKOUT && !gate_out.hs_on && !gate_out.ls_on;
    endproperty
    a_en_fall: assert property (p_en_fall) else $error("enable low did not shut down");

    property p_resume;
        s.st == bsfs_pkg::ST_LOCKOUT && !lock && cmp_in.en_above_on |=> por_ready_out;
    endproperty
    a_resume: assert property (p_resume) else $error("no restart with valid inputs");

    property p_por_ss;
        $rose(por_ready_out) |-> soft_start_level_out == 22'h0 ##1
            (!por_ready_out || s.st != bsfs_pkg::ST_ACTIVE || soft_start_level_out == bsfs_pkg::SS_STEP_UV);
    endproperty
    a_por_ss: assert property (p_por_ss) else $error("soft-start not launched");

    property p_prebias;
        !s.hs_seen && !s.ovp_latch |-> !gate_out.ls_on;
    endproperty
    a_prebias: assert property (p_prebias) else $error("sync on before first pulse");

    property p_ss_force;
        soft_start_level_out <= bsfs_pkg::SS_CLAMP_UV || soft_start_level_out == bsfs_pkg::SS_FORCED_UV;
    endproperty
    a_ss_force: assert property (p_ss_force) else $error("soft-start level out of shape");

    property p_hiccup;
        s.st == bsfs_pkg::ST_HICCUP |-> !gate_out.hs_on && !gate_out.ls_on && !pg_out;
    endproperty
    a_hiccup: assert property (p_hiccup) else $error("output active in blanking");

    property p_thermal;
        s.st == bsfs_pkg::ST_ACTIVE && !lock && cmp_in.temp_hot |=>
            s.st == bsfs_pkg::ST_THERMAL && soft_start_level_out == 22'h0 ##1 !gate_out.hs_on;
    endproperty
    a_thermal: assert property (p_thermal) else $error("thermal trip ignored");

    property p_pg;
        pg_out |-> $past(cmp_in.sns_above_low) && !$past(cmp_in.sns_above_high);
    endproperty
    a_pg: assert property (p_pg) else $error("power-good outside window");

    property p_ovp;
        !lock && cmp_in.sns_above_high && s.ovp_cnt == bsfs_pkg::OVP_DELAY_CYC - 7'h1 |=>
            s.ovp_latch && !gate_out.hs_on && !pg_out;
    endproperty
    a_ovp: assert property (p_ovp) else $error("over-voltage not latched");

    property p_ss_gate;
        gate_out.hs_on |-> $past(soft_start_level_out) > bsfs_pkg::SS_START_UV;
    endproperty
    a_ss_gate: assert property (p_ss_gate) else $error("early switching");

    property p_sync_after_hs;
        $rose(gate_out.ls_on) && !s.ovp_latch |-> $past(gate_out.hs_on) && !gate_out.hs_on;
    endproperty
    a_sync_after_hs: assert property (p_sync_after_hs) else $error("sync not after pulse");

    property p_ocp;
        s.st == bsfs_pkg::ST_ACTIVE && !lock && !cmp_in.temp_hot && s.ls && cmp_in.ocp_over[lim_sel]
            && s.since_rise == 9'(period - eighth) |=> s.st == bsfs_pkg::ST_HICCUP && !pg_out;
    endproperty
    a_ocp: assert property (p_ocp) else $error("over-current missed");

    property p_blank_hold;
        s.st == bsfs_pkg::ST_HICCUP && !lock && !cmp_in.temp_hot && 32'(s.blank_cnt) < HICCUP_CYCLES - 1
            |=> s.st == bsfs_pkg::ST_HICCUP;
    endproperty
    a_blank_hold: assert property (p_blank_hold) else $error("blanking cut short");

    property p_thermal_hold;
        s.st == bsfs_pkg::ST_THERMAL && !lock && !cmp_in.temp_below_hyst |=> s.st == bsfs_pkg::ST_THERMAL;
    endproperty
    a_thermal_hold: assert property (p_thermal_hold) else $error("thermal left early");

    property p_ovp_hold;
        s.ovp_latch && !lock |=> s.ovp_latch && !gate_out.hs_on;
    endproperty
    a_ovp_hold: assert property (p_ovp_hold) else $error("over-voltage latch lost");

    c_hiccup:  cover property (s.st == bsfs_pkg::ST_ACTIVE ##1 s.st == bsfs_pkg::ST_HICCUP);
    c_thermal: cover property (s.st == bsfs_pkg::ST_THERMAL ##1 s.st == bsfs_pkg::ST_ACTIVE);
    c_steady:  cover property (s.step == bsfs_pkg::EIGHTHS && gate_out.ls_on);
    c_ovp:     cover property ($rose(s.ovp_latch));
    c_retry:   cover property (s.st == bsfs_pkg::ST_HICCUP ##1 s.st == bsfs_pkg::ST_ACTIVE);

endmodule
`default_nettype wire

// [bsfs_partner.sv]
// modulator and over-current comparator model facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module bsfs_partner (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       arst_n_in,
    // bench controls
    input  wire logic [3:0] freq_code_in,
    input  wire logic [1:0] limit_sel_in,
    input  wire logic       overload_in,
    // modulator request and valley current flags
    output logic            pwm_out,
    output logic [2:0]      ocp_over_out
);
    logic [11:0] cnt;
    logic [11:0] period;
    ////////////////////////////////////////////////////////////////////////////
    // switching period from the resistor code, top code clamps
    assign period = 12'(40000 / (300 + 100 * ((freq_code_in > 4'hC) ? 12 : int'(freq_code_in))));
    // free-running period counter
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt <= 12'h000;
        end else begin
            cnt <= (cnt >= period - 12'h001) ? 12'h000 : cnt + 12'h001;
        end
    end
    // high-side request for a quarter of each period
    assign pwm_out = (cnt < (period >> 2));
    // overload shows only on the comparator of the selected limit
    assign ocp_over_out = overload_in ? (3'h1 << ((limit_sel_in == 2'h3) ? 2'h0 : limit_sel_in)) : 3'h0;
endmodule
`default_nettype wire

// [bsfs_sequencer_tb.sv]
// self-checking bench of the start-up and fault sequencer
`timescale 1ns/1ps
`default_nettype none
module bsfs_sequencer_tb;
    logic                 clk_in;
    logic                 arst_n_in;
    bsfs_pkg::bsfs_cmp_t  flags;
    bsfs_pkg::bsfs_cmp_t  cmp_in;
    bsfs_pkg::bsfs_gate_t gate;
    logic [1:0]           sel;
    logic [3:0]           freq;
    logic                 overload;
    logic                 pwm;
    logic [2:0]           ocp;
    logic                 pg;
    logic                 por;
    logic                 ramp;
    logic [21:0]          level;
    logic [3:0]           addr;
    logic                 rd;
    logic                 wr;
    logic [31:0]          wdata;
    logic [31:0]          rdata;
    logic [31:0]          got;
    logic                 wait_req;
    logic                 ls_early;
    int                   failures;
    int                   checked;
    int                   n;
    ////////////////////////////////////////////////////////////////////////////
    // comparator flags from the bench, current flags from the partner
    always_comb begin
        cmp_in = flags;
        cmp_in.ocp_over = ocp;
    end
    bsfs_partner i_bsfs_partner (.clk_in(clk_in), .arst_n_in(arst_n_in), .freq_code_in(freq),
        .limit_sel_in(sel), .overload_in(overload), .pwm_out(pwm), .ocp_over_out(ocp));
    bsfs_sequencer #(.RAMP_CYCLES(200), .HICCUP_CYCLES(100)) i_bsfs_sequencer (.clk_in(clk_in),
        .arst_n_in(arst_n_in), .cmp_in(cmp_in), .current_limit_select_in(sel),
        .frequency_set_resistor_in(freq), .pwm_in(pwm), .gate_out(gate), .pg_out(pg),
        .por_ready_out(por), .ramp_active_out(ramp), .soft_start_level_out(level),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req));
    ////////////////////////////////////////////////////////////////////////////
    // value comparison
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic write, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int k;
        k = 0;
        @(posedge clk_in);
        rd <= !write;
        wr <= write;
        addr <= a;
        wdata <= d;
        do begin
            @(posedge clk_in);
            k++;
        end while (wait_req !== 1'b0 && k < 20);
        if (k >= 20) check("waitrequest", 32'h0, 32'h1);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(negedge clk_in);
    endtask
    // counts and verdict
    task automatic end_sim();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // clock
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    // watchdog
    initial begin
        repeat (90000) @(posedge clk_in);
        failures++;
        end_sim();
    end
    // test sequence
    initial begin
        arst_n_in = 1'b0; flags = '0; sel = 2'h1; freq = 4'hC; overload = 1'b0;
        addr = 4'h0; rd = 1'b0; wr = 1'b0; wdata = 32'h0; failures = 0; checked = 0; ls_early = 1'b0;
        repeat (2) @(posedge clk_in);
        arst_n_in <= 1'b1;
        @(negedge clk_in);
        check("gates", 32'h0, gate);
        check("pg", 32'h0, pg);
        bus(1'b0, bsfs_pkg::REG_STATUS, 32'h0, got);
        check("state", 32'h0, got[1:0]);
        bus(1'b0, 4'h2, 32'h0, got);
        check("unmapped", 32'h0, got);
        @(posedge clk_in);
        flags.bias_ok <= 1'b1;
        flags.en_above_off <= 1'b1;
        repeat (4) @(negedge clk_in);
        check("por_early", 32'h0, por);
        @(posedge clk_in);
        flags.en_above_on <= 1'b1;
        repeat (2) @(negedge clk_in);
        check("por", 32'h1, por);
        $display("test lockout done");
        n = 0;
        while (gate.hs_on !== 1'b1 && n < 31000) begin
            @(negedge clk_in);
            n++;
            if (gate.ls_on !== 1'b0) ls_early = 1'b1;
        end
        check("ss_delay", 32'h1, (n >= 29990 && n <= 30060));
        check("level_at_switch", 32'h1, level > bsfs_pkg::SS_START_UV);
        check("ramp", 32'h1, ramp);
        check("ls_before_hs", 32'h0, ls_early);
        n = 0;
        while (gate.ls_on !== 1'b1 && n < 100) begin
            @(negedge clk_in);
            n++;
        end
        n = 0;
        while (gate.ls_on === 1'b1 && n < 100) begin
            @(negedge clk_in);
            n++;
        end
        check("ls_width", 32'h1 * ((40000 / 1500) / 8), n);
        @(posedge clk_in);
        flags.sns_above_low <= 1'b1;
        repeat (3) @(negedge clk_in);
        check("pg_in_window", 32'h1, pg);
        @(posedge clk_in);
        flags.sns_above_high <= 1'b1;
        repeat (3) @(negedge clk_in);
        check("pg_above", 32'h0, pg);
        @(posedge clk_in);
        flags.sns_above_high <= 1'b0;
        $display("test soft start done");
        repeat (3600) @(negedge clk_in);
        bus(1'b0, bsfs_pkg::REG_STATUS, 32'h0, got);
        check("ls_step", 32'h8, got[12:9]);
        @(posedge clk_in);
        overload <= 1'b1;
        n = 0;
        while (gate !== 2'b00 && n < 60) begin
            @(negedge clk_in);
            n++;
        end
        check("hiccup_gates", 32'h0, gate);
        check("hiccup_pg", 32'h0, pg);
        bus(1'b0, bsfs_pkg::REG_STATUS, 32'h0, got);
        check("hiccup_state", 32'h2, got[1:0]);
        bus(1'b0, bsfs_pkg::REG_FAULTS, 32'h0, got);
        check("faults", 32'h1, got);
        @(posedge clk_in);
        overload <= 1'b0;
        repeat (110) @(negedge clk_in);
        bus(1'b0, bsfs_pkg::REG_STATUS, 32'h0, got);
        check("retry_state", 32'h1, got[1:0]);
        check("retry_level", 32'h1, level < 22'h000800);
        $display("test over-current done");
        @(posedge clk_in);
        flags.temp_hot <= 1'b1;
        repeat (3) @(negedge clk_in);
        check("thermal_level", 32'h0, level);
        @(posedge clk_in);
        flags.temp_hot <= 1'b0;
        repeat (3) @(negedge clk_in);
        bus(1'b0, bsfs_pkg::REG_STATUS, 32'h0, got);
        check("thermal_hold", 32'h3, got[1:0]);
        @(posedge clk_in);
        flags.temp_below_hyst <= 1'b1;
        repeat (3) @(negedge clk_in);
        check("thermal_exit", 32'h1, level != 22'h0);
        bus(1'b0, bsfs_pkg::REG_STATUS, 32'h0, got);
        check("thermal_state", 32'h1, got[1:0]);
        $display("test thermal done");
        @(posedge clk_in);
        flags.sns_above_high <= 1'b1;
        repeat (90) @(negedge clk_in);
        check("ovp_gates", 32'h1, gate);
        bus(1'b0, bsfs_pkg::REG_STATUS, 32'h0, got);
        check("ovp_flag", 32'h1, got[3]);
        check("ovp_pg", 32'h0, pg);
        @(posedge clk_in);
        flags.sns_above_high <= 1'b0;
        flags.en_above_off <= 1'b0;
        flags.en_above_on <= 1'b0;
        repeat (3) @(negedge clk_in);
        check("off_gates", 32'h0, gate);
        check("off_por", 32'h0, por);
        @(posedge clk_in);
        flags.en_above_off <= 1'b1;
        flags.en_above_on <= 1'b1;
        repeat (3) @(negedge clk_in);
        bus(1'b0, bsfs_pkg::REG_STATUS, 32'h0, got);
        check("ovp_cleared", 32'h0, got[3]);
        check("resume", 32'h1, got[1:0]);
        bus(1'b1, bsfs_pkg::REG_CTRL, 32'h1, got);
        repeat (2) @(negedge clk_in);
        check("sw_off_por", 32'h0, por);
        bus(1'b0, bsfs_pkg::REG_CTRL, 32'h0, got);
        check("ctrl", 32'h1, got);
        $display("test shutdown done");
        end_sim();
    end
endmodule
`default_nettype wire
